// >>> core/bcw_bus_cycle.sv
// Bus cycle sequencer with wait-state generator and bus hand-over.
// Assumes pins come from outside the clock domain; core requests are
// synchronous to pclk; one T-state lasts one pclk period.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ns
module bcw_bus_cycle (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic req_valid,
    input wire logic [2:0] req_kind,
    input wire logic [19:0] req_addr,
    input wire logic req_write,
    input wire logic [7:0] req_wdata,
    input wire logic [2:0] onchip_waits,
    output logic req_ready,
    output logic req_done,
    output logic [7:0] req_rdata,
    output logic core_restart,
    input wire logic reset_pin_n,
    input wire logic wait_n,
    input wire logic bus_request_n,
    input wire logic [7:0] data_in,
    output logic [19:0] addr_out,
    output logic addr_oe,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic mem_request_n,
    output logic io_request_n,
    output logic rd_n,
    output logic wr_n,
    output logic ctrl_oe,
    output logic fetch_cycle_n,
    output logic bus_grant_n,
    output logic refresh_ok
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pin_meta_q; // First stage, read only by second
    logic [2:0] pin_sync_q; // {reset_pin_n, wait_n, bus_request_n}
    logic rst_pin_n;
    logic wait_s_n;
    logic bus_request_n_s_n;

    // Two flops per pin; a single stage would let metastability leak
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_meta_q <= 3'h7;
            pin_sync_q <= 3'h7;
        end
        else
        begin
            pin_meta_q <= {reset_pin_n, wait_n, bus_request_n};
            pin_sync_q <= pin_meta_q;
        end
    end

    assign rst_pin_n = pin_sync_q[2];
    assign wait_s_n = pin_sync_q[1]; // Cleanly sampled if driver is synchronous
    assign bus_request_n_s_n = pin_sync_q[0];

    // ------------------------------------------------------------
    // Reset pin timer
    // ------------------------------------------------------------
    logic [2:0] rst_cnt_q; // Low clocks seen so far
    logic rst_hold_q; // Pin reset in force
    logic rst_hit;

    assign rst_hit = !rst_pin_n && (rst_cnt_q == bcw_pkg::RST_PIN_CYCLES - 3'h1);

    // Short glitches below six clocks are ignored
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rst_cnt_q <= 3'h0;
            rst_hold_q <= 1'b0;
        end
        else if (rst_pin_n)
        begin
            rst_cnt_q <= 3'h0;
            rst_hold_q <= 1'b0;
        end
        else
        begin
            if (rst_cnt_q != bcw_pkg::RST_PIN_CYCLES)
                rst_cnt_q <= rst_cnt_q + 3'h1;
            if (rst_hit)
                rst_hold_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Registers over APB
    // ------------------------------------------------------------
    logic [7:0] wait_ctrl_q; // dma_wait_control
    logic io_timing_sel_q; // Low: strobes from T2
    logic apb_access;
    logic [1:0] mem_sel;
    logic [1:0] io_sel;
    bcw_pkg::state_type state_q;
    bcw_pkg::state_type state_d;

    assign apb_access = psel && penable && !pready;
    assign mem_sel = wait_ctrl_q[bcw_pkg::MEM_WAIT_LSB +: 2];
    assign io_sel = wait_ctrl_q[bcw_pkg::IO_WAIT_LSB +: 2];

    // Writes land on the completing edge; pin reset also restores waits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_ctrl_q <= bcw_pkg::WAIT_CTRL_RST;
            io_timing_sel_q <= bcw_pkg::IO_TIMING_RST;
        end
        else if (rst_hold_q || rst_hit)
        begin
            wait_ctrl_q <= bcw_pkg::WAIT_CTRL_RST;
            io_timing_sel_q <= bcw_pkg::IO_TIMING_RST;
        end
        else if (psel && penable && pready && pwrite)
        begin
            if (paddr == bcw_pkg::OFS_WAIT_CTRL)
                wait_ctrl_q <= pwdata[7:0];
            if (paddr == bcw_pkg::OFS_BUS_MODE)
                io_timing_sel_q <= pwdata[0];
        end
    end

    // One wait cycle per access keeps pready a flop output
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end
        else
        begin
            pready <= apb_access;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            if (apb_access)
            begin
                case (paddr)
                    bcw_pkg::OFS_WAIT_CTRL: prdata <= {24'h0, wait_ctrl_q};
                    bcw_pkg::OFS_BUS_MODE: prdata <= {31'h0, io_timing_sel_q};
                    bcw_pkg::OFS_STATUS: prdata <= {27'h0, rst_hold_q, 1'b0, state_q};
                    default: pslverr <= 1'b1; // Unmapped word
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Wait count per cycle kind
    // ------------------------------------------------------------
    logic [2:0] auto_waits; // Generator count for the pending cycle
    logic [2:0] kind_q;
    logic [19:0] addr_q;
    logic write_q;
    logic onchip_q;

    // Generator count chosen from kind and field settings, or from onchip_waits for on-chip I/O
    always_comb
    begin
        auto_waits = 3'h0;
        case (kind_q)
            bcw_pkg::KIND_FETCH,
            bcw_pkg::KIND_MEM,
            bcw_pkg::KIND_ACK_MEM: auto_waits = {1'b0, mem_sel};
            bcw_pkg::KIND_IO:
            begin
                if (onchip_q)
                    auto_waits = onchip_waits;
                else
                    auto_waits = {1'b0, io_sel} + bcw_pkg::IO_EXTRA_WAIT;
            end
            bcw_pkg::KIND_IRQ0_ACK:
            begin
                case (io_sel)
                    2'h0: auto_waits = 3'h2;
                    2'h1: auto_waits = 3'h4;
                    2'h2: auto_waits = 3'h5;
                    default: auto_waits = 3'h6;
                endcase
            end
            default: auto_waits = 3'h0;
        endcase
    end

    // ------------------------------------------------------------
    // Machine cycle sequencer
    // ------------------------------------------------------------
    logic [2:0] wait_cnt_q; // Generator waits still owed
    logic bus_request_n_pend_q; // Sampled before T3
    logic ext_wait;

    assign ext_wait = !wait_s_n && !rst_hold_q;

    // Next state; release decided only where a machine cycle ends
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            bcw_pkg::ST_IDLE,
            bcw_pkg::ST_T3:
            begin
                if (!bus_request_n_s_n || (state_q == bcw_pkg::ST_T3 && bus_request_n_pend_q))
                    state_d = bcw_pkg::ST_TX;
                else if (req_valid && req_kind != bcw_pkg::KIND_INTERNAL)
                    state_d = bcw_pkg::ST_T1;
                else
                    state_d = bcw_pkg::ST_IDLE;
            end
            bcw_pkg::ST_T1: state_d = bcw_pkg::ST_T2;
            bcw_pkg::ST_T2,
            bcw_pkg::ST_TW:
            begin
                if (wait_cnt_q != 3'h0 || ext_wait)
                    state_d = bcw_pkg::ST_TW;
                else
                    state_d = bcw_pkg::ST_T3;
            end
            bcw_pkg::ST_TX:
            begin
                if (!bus_request_n_s_n)
                    state_d = bcw_pkg::ST_TX;
                else
                    state_d = bcw_pkg::ST_IDLE;
            end
            bcw_pkg::ST_RESET: state_d = bcw_pkg::ST_IDLE;
            default: state_d = bcw_pkg::ST_IDLE;
        endcase
        if (rst_hold_q || rst_hit)
            state_d = bcw_pkg::ST_RESET;
    end

    // State, wait counter and request latch
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= bcw_pkg::ST_RESET;
            wait_cnt_q <= 3'h0;
            bus_request_n_pend_q <= 1'b0;
            kind_q <= bcw_pkg::KIND_INTERNAL;
            addr_q <= 20'h0;
            write_q <= 1'b0;
            onchip_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            if (state_q == bcw_pkg::ST_T1)
                wait_cnt_q <= auto_waits;
            else if ((state_q == bcw_pkg::ST_T2 || state_q == bcw_pkg::ST_TW) && wait_cnt_q != 3'h0)
                wait_cnt_q <= wait_cnt_q - 3'h1;
            if (state_d == bcw_pkg::ST_T3 && state_q != bcw_pkg::ST_T3)
                bus_request_n_pend_q <= !bus_request_n_s_n;
            else if (state_q == bcw_pkg::ST_T3)
                bus_request_n_pend_q <= 1'b0;
            if (state_d == bcw_pkg::ST_T1)
            begin
                kind_q <= req_kind;
                write_q <= req_write;
                onchip_q <= (req_kind == bcw_pkg::KIND_IO) && (req_addr[15:0] <= bcw_pkg::ONCHIP_IO_TOP);
                // I/O address is untranslated, upper four lines low
                if (req_kind == bcw_pkg::KIND_IO)
                    addr_q <= {4'h0, req_addr[15:0]};
                else
                    addr_q <= req_addr;
            end
        end
    end

    // ------------------------------------------------------------
    // Core handshake
    // ------------------------------------------------------------
    // Ready marks the edge a request is taken; done ends it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            req_ready <= 1'b0;
            req_done <= 1'b0;
            req_rdata <= 8'h0;
            core_restart <= 1'b0;
        end
        else
        begin
            req_ready <= (state_d == bcw_pkg::ST_IDLE || state_d == bcw_pkg::ST_T3);
            req_done <= (state_q == bcw_pkg::ST_T3) && !rst_hold_q;
            if (state_q == bcw_pkg::ST_T3 && !write_q)
                req_rdata <= data_in;
            core_restart <= (state_q == bcw_pkg::ST_RESET) && !rst_hold_q;
        end
    end

    // ------------------------------------------------------------
    // Bus pins
    // ------------------------------------------------------------
    logic in_bus_d;
    logic io_d;
    logic strobe_on_d;
    logic io_new; // Kind of the request being taken, latch not yet loaded

    assign in_bus_d = state_d == bcw_pkg::ST_T1 || state_d == bcw_pkg::ST_T2 ||
                      state_d == bcw_pkg::ST_TW || state_d == bcw_pkg::ST_T3;
    // Selected timing holds io strobes off through T1
    assign io_d = kind_q == bcw_pkg::KIND_IO || kind_q == bcw_pkg::KIND_IRQ0_ACK;
    assign strobe_on_d = in_bus_d && !(state_d == bcw_pkg::ST_T1 && io_d && !io_timing_sel_q);
    assign io_new = req_kind == bcw_pkg::KIND_IO || req_kind == bcw_pkg::KIND_IRQ0_ACK;

    // Pins follow next state so each comes straight from a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            addr_out <= bcw_pkg::RESTART_ADDR;
            addr_oe <= 1'b1;
            data_out <= 8'h0;
            data_oe <= 1'b0;
            mem_request_n <= 1'b1;
            io_request_n <= 1'b1;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            ctrl_oe <= 1'b1;
            fetch_cycle_n <= 1'b1;
            bus_grant_n <= 1'b1;
            refresh_ok <= 1'b0;
        end
        else
        begin
            // Released bus floats; grant only after the float
            addr_oe <= state_d != bcw_pkg::ST_TX;
            ctrl_oe <= state_d != bcw_pkg::ST_TX;
            bus_grant_n <= !(state_d == bcw_pkg::ST_TX && state_q == bcw_pkg::ST_TX);
            refresh_ok <= state_d == bcw_pkg::ST_IDLE;
            addr_out <= (state_d == bcw_pkg::ST_RESET) ? bcw_pkg::RESTART_ADDR : addr_q;
            if (state_d == bcw_pkg::ST_T1)
                addr_out <= (req_kind == bcw_pkg::KIND_IO) ? {4'h0, req_addr[15:0]} : req_addr;
            data_out <= req_wdata;
            data_oe <= 1'b0;
            mem_request_n <= 1'b1;
            io_request_n <= 1'b1;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            fetch_cycle_n <= 1'b1;
            if (in_bus_d && state_d != bcw_pkg::ST_T1)
            begin
                data_oe <= write_q && !io_d;
                if (io_d && kind_q == bcw_pkg::KIND_IO)
                    data_oe <= write_q;
                mem_request_n <= io_d;
                io_request_n <= !(io_d && strobe_on_d);
                rd_n <= !(!write_q && strobe_on_d);
                wr_n <= !write_q;
                fetch_cycle_n <= !(kind_q == bcw_pkg::KIND_FETCH || kind_q == bcw_pkg::KIND_IRQ0_ACK);
            end
            else if (state_d == bcw_pkg::ST_T1)
            begin
                // Latched kind is stale here, so decode the incoming request
                mem_request_n <= io_new;
                io_request_n <= !(io_new && io_timing_sel_q);
                rd_n <= !(!req_write && (!io_new || io_timing_sel_q));
                fetch_cycle_n <= !(req_kind == bcw_pkg::KIND_FETCH || req_kind == bcw_pkg::KIND_IRQ0_ACK);
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    io_upper_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        !io_request_n |-> addr_out[19:16] == 4'h0 && mem_request_n)
        else $error("io cycle with memory strobe or upper address set");
    ext_io_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == bcw_pkg::ST_T2 && kind_q == bcw_pkg::KIND_IO && !onchip_q |=> state_q == bcw_pkg::ST_TW)
        else $error("external io cycle without wait");
    pin_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
        rst_hit |=> state_q == bcw_pkg::ST_RESET && wait_ctrl_q == bcw_pkg::WAIT_CTRL_RST)
        else $error("reset pin not honoured");
    grant_after_float_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(bus_grant_n) |-> !addr_oe && $past(!addr_oe))
        else $error("grant before bus float");
    release_boundary_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == bcw_pkg::ST_TX && $past(state_q) != bcw_pkg::ST_TX |->
        $past(state_q) == bcw_pkg::ST_IDLE || $past(state_q) == bcw_pkg::ST_T3)
        else $error("release mid cycle");
    float_pins_a: assert property (@(posedge pclk) disable iff (!presetn)
        !bus_grant_n |-> !addr_oe && !ctrl_oe && !data_oe)
        else $error("bus driven while granted");
    no_refresh_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == bcw_pkg::ST_TW || state_q == bcw_pkg::ST_TX |-> !refresh_ok)
        else $error("refresh during wait or release");
    mem_waits_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == bcw_pkg::ST_T1 && kind_q == bcw_pkg::KIND_MEM && mem_sel == 2'h3 && !rst_hold_q
        |=> state_q == bcw_pkg::ST_T2 ##1 state_q == bcw_pkg::ST_TW [*3])
        else $error("memory waits short");
    irq0_waits_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == bcw_pkg::ST_T1 && kind_q == bcw_pkg::KIND_IRQ0_ACK && io_sel == 2'h0 |=> ##1 wait_cnt_q == 3'h1)
        else $error("interrupt acknowledge wait count wrong");
    strobe_timing_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == bcw_pkg::ST_T1 && !io_timing_sel_q && kind_q == bcw_pkg::KIND_IO |-> io_request_n && rd_n)
        else $error("io strobe active in T1");
    release_c: cover property (@(posedge pclk) disable iff (!presetn) $fell(bus_grant_n));
    ext_wait_c: cover property (@(posedge pclk) disable iff (!presetn) state_q == bcw_pkg::ST_TW && ext_wait);
    restart_c: cover property (@(posedge pclk) disable iff (!presetn) core_restart);

endmodule : bcw_bus_cycle

// >>> core/bcw_pkg.sv
// Constants and types shared by the bus cycle and wait controller.
// Assumes a single 100 MHz clock and an APB slave with 32-bit data.
package bcw_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_WAIT_CTRL = 8'h00; // dma_wait_control
    localparam logic [7:0] OFS_BUS_MODE = 8'h04; // io_timing_sel in bit 0
    localparam logic [7:0] OFS_STATUS = 8'h08; // read-only bus state

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int MEM_WAIT_LSB = 6; // mem_wait_sel_hi/lo
    localparam int IO_WAIT_LSB = 4; // io_wait_sel_hi/lo
    localparam logic [7:0] WAIT_CTRL_RST = 8'hf0; // All wait selects high
    localparam logic IO_TIMING_RST = 1'b1; // Legacy strobe timing
    localparam logic [19:0] RESTART_ADDR = 20'h00000; // Restart point
    localparam logic [15:0] ONCHIP_IO_TOP = 16'h003f; // Last on-chip port

    // ------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------
    localparam logic [2:0] RST_PIN_CYCLES = 3'h6; // Low clocks for restart
    localparam logic [2:0] IO_EXTRA_WAIT = 3'h1; // Minimum external I/O wait

    // ------------------------------------------------------------
    // Cycle kinds offered by the core
    // ------------------------------------------------------------
    localparam logic [2:0] KIND_INTERNAL = 3'h0; // One-clock internal op
    localparam logic [2:0] KIND_FETCH = 3'h1; // Opcode fetch
    localparam logic [2:0] KIND_MEM = 3'h2; // Memory read or write
    localparam logic [2:0] KIND_IO = 3'h3; // I/O read or write
    localparam logic [2:0] KIND_IRQ0_ACK = 3'h4; // ext_irq_zero acknowledge
    localparam logic [2:0] KIND_ACK_MEM = 3'h5; // Vector read, PC stacking

    // ------------------------------------------------------------
    // Bus states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_T1,
        ST_T2,
        ST_TW,
        ST_T3,
        ST_TX,
        ST_RESET
    } state_type;

endpackage : bcw_pkg

// >>> verif/bcw_far_side.sv
// Far-side model: memory and I/O ports with a wait line.
// Assumes strobes and address come from the DUT on pclk.
`timescale 1ns/1ns
module bcw_far_side (
    input wire logic pclk,
    input wire logic [19:0] addr_out,
    input wire logic rd_n,
    input wire logic [3:0] stall,
    output logic [7:0] data_in,
    output logic wait_n
);
    logic [3:0] cnt_q = 4'h0; // Wait cycles still owed
    initial wait_n = 1'b1;
    initial data_in = 8'h00;
    // Wait line moves only just after rising edges
    always @(posedge pclk)
    begin
        if (rd_n)
            cnt_q <= stall;
        else if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
        // A slow device holds wait low ahead of its access
        wait_n <= rd_n ? (stall == 4'h0) : (cnt_q == 4'h0);
    end
    // Released data bus toggles so a stale byte never looks valid
    always @(posedge pclk)
        data_in <= rd_n ? ~data_in : (addr_out[7:0] ^ 8'h5a);
endmodule : bcw_far_side

// >>> verif/tb.sv
// Testbench: APB register tasks and core bus cycle tasks.
// Assumes the DUT updates outputs with non-blocking assignments.
`timescale 1ns/1ns
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, req_valid, req_ready, req_done, core_restart;
    logic reset_pin_n, wait_n, bus_request_n, addr_oe, ctrl_oe, mem_request_n, io_request_n, rd_n;
    logic bus_grant_n, refresh_ok, t1_io, io2, mem2;
    logic [7:0] paddr, req_rdata, data_in;
    logic [31:0] pwdata, prdata;
    logic [2:0] req_kind, onchip_waits;
    logic [19:0] req_addr, addr_out;
    logic [3:0] stall, hi2;
    int fail_count = 0, n_tests = 0, cyc = 0, ticks = 0;
    bcw_bus_cycle DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .req_valid, .req_kind, .req_addr, .req_write(1'b0), .req_wdata(8'h00), .onchip_waits, .req_ready,
        .req_done, .req_rdata, .core_restart, .reset_pin_n, .wait_n, .bus_request_n, .data_in, .addr_out,
        .addr_oe, .data_out(), .data_oe(), .mem_request_n, .io_request_n, .rd_n, .wr_n(), .ctrl_oe,
        .fetch_cycle_n(), .bus_grant_n, .refresh_ok);
    bcw_far_side far (.pclk, .addr_out, .rd_n, .stall, .data_in, .wait_n);
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] exp,
        input logic experr);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        if (!wr)
            chk({prdata[7:0], 7'h00, pslverr}, {exp[7:0], 7'h00, experr});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // One core cycle; counts edges from take to done, expects 4 plus waits
    task automatic run(input logic [2:0] kind, input logic [19:0] a, input int w);
        int n;
        req_kind <= kind;
        req_addr <= a;
        req_valid <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (req_ready !== 1'b1 && n < 50)
        begin
            @(posedge pclk);
            n++;
        end
        req_valid <= 1'b0;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
            if (n == 1)
                t1_io = io_request_n;
            if (n == 2)
                {io2, mem2, hi2} = {io_request_n, mem_request_n, addr_out[19:16]};
        end
        while (req_done !== 1'b1 && n < 60);
        cyc = n;
        if (w >= 0)
            chk(32'(n), 32'(4 + w));
    endtask : run
    // Hang guard
    always @(posedge pclk)
    begin
        ticks++;
        if (ticks == 5000)
        begin
            fail_count++;
            test_done();
        end
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        {presetn, psel, penable, pwrite, req_valid, paddr, pwdata, req_kind, req_addr} = '0;
        {onchip_waits, stall} = '0;
        {reset_pin_n, bus_request_n} = 2'b11;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        apb(1'b0, bcw_pkg::OFS_WAIT_CTRL, 0, 32'hf0, 1'b0);
        apb(1'b0, 8'h0c, 0, 32'h0, 1'b1);
        for (int c = 0; c < 4; c++)
        begin
            apb(1'b1, bcw_pkg::OFS_WAIT_CTRL, 32'({c[1:0], c[1:0], 4'h0}), 0, 1'b0);
            run(bcw_pkg::KIND_MEM, 20'h12345, c);
            chk(32'(req_rdata), 32'h1f);
            run(bcw_pkg::KIND_ACK_MEM, 20'h00100, c);
            run(bcw_pkg::KIND_IO, 20'hf0280, c + 1);
            chk({io2, mem2, hi2}, 6'h10);
            run(bcw_pkg::KIND_IRQ0_ACK, 20'h00000, (c == 0) ? 2 : c + 3);
        end
        run(bcw_pkg::KIND_IO, 20'h00010, 0);
        onchip_waits <= 3'h4;
        run(bcw_pkg::KIND_IO, 20'h0003f, 4);
        run(bcw_pkg::KIND_IO, 20'h00040, 4);
        apb(1'b1, bcw_pkg::OFS_BUS_MODE, 32'h0, 0, 1'b0);
        run(bcw_pkg::KIND_IO, 20'h00280, 4);
        chk({t1_io, io2}, 2'b10);
        apb(1'b1, bcw_pkg::OFS_WAIT_CTRL, 32'h0, 0, 1'b0);
        stall <= 4'h6;
        repeat (4) @(posedge pclk);
        run(bcw_pkg::KIND_MEM, 20'h00200, -1);
        chk(32'(cyc > 4), 32'h1);
        stall <= 4'h0;
        bus_request_n <= 1'b0;
        for (int k = 0; k < 20 && bus_grant_n !== 1'b0; k++)
            @(posedge pclk);
        chk({bus_grant_n, addr_oe, ctrl_oe, refresh_ok}, 4'h0);
        bus_request_n <= 1'b1;
        for (int k = 0; k < 20 && bus_grant_n !== 1'b1; k++)
            @(posedge pclk);
        chk({bus_grant_n, addr_oe}, 2'b11);
        reset_pin_n <= 1'b0;
        repeat (10) @(posedge pclk);
        reset_pin_n <= 1'b1;
        for (int k = 0; k < 20 && core_restart !== 1'b1; k++)
            @(posedge pclk);
        chk(core_restart, 1'b1);
        @(posedge pclk);
        apb(1'b0, bcw_pkg::OFS_WAIT_CTRL, 0, 32'hf0, 1'b0);
        test_done();
    end
endmodule : tb
